//--- rtl/port0_digital_waveform_io.sv
// Port 0 static and hardware-timed waveform digital I/O with APB registers
`include "port0_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module port0_digital_waveform_io
    import port0_pkg::*;
#(
    parameter int ACQ_AW = 4,
    parameter int GEN_AW = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] port0_lines_in,
    output logic [31:0] port0_lines_out,
    output logic [31:0] port0_lines_oe,
    input wire logic [15:0] programmable_function_pin_in,
    output logic [15:0] programmable_function_pin_out,
    output logic [15:0] programmable_function_pin_oe,
    input wire logic [7:0] trigger_bus_line_in,
    input wire logic pxi_star_in,
    input wire logic analog_in_sample_strobe,
    input wire logic analog_in_convert_strobe,
    input wire logic analog_out_sample_strobe,
    input wire logic counter0_internal_output,
    input wire logic counter1_internal_output,
    input wire logic frequency_output,
    input wire logic change_detection_output,
    input wire logic analog_comparison_event,
    output logic counter0_direction_input,
    output logic counter1_direction_input,
    output logic acq_dma_valid,
    output logic [31:0] acq_dma_data,
    input wire logic acq_dma_ready,
    input wire logic gen_dma_valid,
    input wire logic [31:0] gen_dma_data,
    output logic gen_dma_ready
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int PW = 57;
    logic [PW-1:0] pin_raw, s1_r, s2_r, s3_r, pin_f_r;
    assign pin_raw = {pxi_star_in, trigger_bus_line_in, programmable_function_pin_in, port0_lines_in};
    // Level accepted only when stages two and three agree
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_f_r <= '0;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_f_r <= (s2_r & s3_r) | (pin_f_r & (s2_r | s3_r));
        end
    end
    wire [31:0] lines_f = pin_f_r[31:0];
    wire [15:0] pfi_f = pin_f_r[47:32];
    wire [7:0] trig_f = pin_f_r[55:48];
    wire star_f = pin_f_r[56];

    // ------------------------------------------------------------
    // Registers and APB decode
    // ------------------------------------------------------------
    logic [31:0] dir_r, wave_r, sout_r, dicfg_r, docfg_r, route_r;
    logic [15:0] pdir_r, pout_r;
    logic [2:0] err_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready_r & pwrite;
    wire rd_hit = (paddr[1:0] == 2'h0) & (paddr <= `P0_OFS_CTRDIR);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Source table: internal strobes first, then PFI, trigger bus and star, then the analog comparison event, all without a divider
    logic [`SRC_COUNT-1:0] src_vec;
    assign src_vec = {analog_comparison_event, star_f, trig_f, pfi_f, change_detection_output,
                      frequency_output, counter1_internal_output, counter0_internal_output,
                      analog_out_sample_strobe, analog_in_convert_strobe, analog_in_sample_strobe};
    function automatic logic pick(input logic [`SRC_COUNT-1:0] v, input src_sel_t s);
        pick = (s < 6'(`SRC_COUNT)) ? v[s] : 1'b0;
    endfunction : pick
    wire di_lvl = pick(src_vec, dicfg_r[`CFG_SRC_MSB:`CFG_SRC_LSB]) ^ dicfg_r[`CFG_POL_BIT];
    wire do_lvl = pick(src_vec, docfg_r[`CFG_SRC_MSB:`CFG_SRC_LSB]) ^ docfg_r[`CFG_POL_BIT];
    logic di_prev_r, do_prev_r;
    // Polarity flips the level, so a rising edge is always the active one
    wire di_edge = di_lvl & ~di_prev_r & dicfg_r[`CFG_EN_BIT];
    wire do_edge = do_lvl & ~do_prev_r & docfg_r[`CFG_EN_BIT];

    // ------------------------------------------------------------
    // Acquisition FIFO
    // ------------------------------------------------------------
    localparam int AD = 1 << ACQ_AW;
    logic [31:0] acq_mem [AD];
    logic [ACQ_AW:0] aw_ptr_r, ar_ptr_r;
    wire acq_empty = (aw_ptr_r == ar_ptr_r);
    wire acq_full = (aw_ptr_r[ACQ_AW] != ar_ptr_r[ACQ_AW]) &&
                    (aw_ptr_r[ACQ_AW-1:0] == ar_ptr_r[ACQ_AW-1:0]);
    wire acq_wr = di_edge & ~acq_full;
    logic acq_v_r;
    logic [31:0] acq_d_r;
    wire acq_ld = ~acq_empty & (~acq_v_r | acq_dma_ready);
    always_ff @(posedge mclk) begin
        if (acq_wr) begin
            acq_mem[aw_ptr_r[ACQ_AW-1:0]] <= lines_f;
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_ptr_r <= '0;
            ar_ptr_r <= '0;
            acq_v_r <= 1'b0;
            acq_d_r <= '0;
        end else begin
            if (acq_wr) begin
                aw_ptr_r <= aw_ptr_r + 1'b1;
            end
            // Output stage stalls until the DMA takes the word
            if (acq_ld) begin
                acq_d_r <= acq_mem[ar_ptr_r[ACQ_AW-1:0]];
                ar_ptr_r <= ar_ptr_r + 1'b1;
                acq_v_r <= 1'b1;
            end else if (acq_dma_ready) begin
                acq_v_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Generation FIFO with retransmit
    // ------------------------------------------------------------
    localparam int GD = 1 << GEN_AW;
    logic [31:0] gen_mem [GD];
    logic [GEN_AW:0] gw_ptr_r, gr_ptr_r, gf_ptr_r;
    logic pf_v_r, gen_rdy_r;
    logic [31:0] pf_d_r, wave_out_r;
    wire rt_mode = docfg_r[`CFG_RT_BIT];
    wire gen_full = (gw_ptr_r[GEN_AW] != gr_ptr_r[GEN_AW]) &&
                    (gw_ptr_r[GEN_AW-1:0] == gr_ptr_r[GEN_AW-1:0]);
    wire gen_wr = gen_dma_valid & gen_rdy_r;
    // Wrap decided at fetch time, so words still arriving from DMA join the loop
    wire [GEN_AW:0] fa = (rt_mode && gf_ptr_r == gw_ptr_r) ? gr_ptr_r : gf_ptr_r;
    wire fetch_ok = (fa != gw_ptr_r);
    wire take = do_edge & pf_v_r;
    wire fetch = fetch_ok & (~pf_v_r | take);
    wire [GEN_AW:0] gf_inc = fa + 1'b1;
    wire gen_unf = do_edge & ~pf_v_r & ~fetch_ok;
    wire gen_ovr = do_edge & ~pf_v_r & fetch_ok;
    always_ff @(posedge mclk) begin
        if (gen_wr) begin
            gen_mem[gw_ptr_r[GEN_AW-1:0]] <= gen_dma_data;
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gw_ptr_r <= '0;
            gr_ptr_r <= '0;
            gf_ptr_r <= '0;
            pf_v_r <= 1'b0;
            pf_d_r <= '0;
            wave_out_r <= '0;
            gen_rdy_r <= 1'b0;
        end else begin
            gen_rdy_r <= ~gen_full & ~(gen_wr & ((gw_ptr_r + 1'b1) - gr_ptr_r) == (GEN_AW+1)'(GD));
            if (gen_wr) begin
                gw_ptr_r <= gw_ptr_r + 1'b1;
            end
            if (take) begin
                wave_out_r <= pf_d_r;
            end
            if (fetch) begin
                pf_d_r <= gen_mem[fa[GEN_AW-1:0]];
                gf_ptr_r <= gf_inc;
                if (!rt_mode) begin
                    gr_ptr_r <= gf_inc;
                end
            end
            pf_v_r <= fetch | (pf_v_r & ~take);
        end
    end

    // ------------------------------------------------------------
    // Register writes, errors, edge history
    // ------------------------------------------------------------
    wire [2:0] err_set = {gen_ovr, gen_unf, di_edge & acq_full};
    wire [2:0] err_clr = (wr_en && hit(paddr, `P0_OFS_STAT)) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dir_r <= `P0_RST_ZERO;
            wave_r <= `P0_RST_ZERO;
            sout_r <= `P0_RST_ZERO;
            dicfg_r <= `P0_RST_ZERO;
            docfg_r <= `P0_RST_ZERO;
            route_r <= `P0_RST_ZERO;
            pdir_r <= '0;
            pout_r <= '0;
            err_r <= '0;
            di_prev_r <= 1'b0;
            do_prev_r <= 1'b0;
        end else begin
            di_prev_r <= di_lvl;
            do_prev_r <= do_lvl;
            // Set wins over a write-one clear in the same cycle
            err_r <= (err_r & ~err_clr) | err_set;
            if (wr_en) begin
                if (hit(paddr, `P0_OFS_DIR)) dir_r <= pwdata;
                if (hit(paddr, `P0_OFS_WAVE)) wave_r <= pwdata;
                if (hit(paddr, `P0_OFS_SOUT)) sout_r <= pwdata;
                if (hit(paddr, `P0_OFS_PDIR)) pdir_r <= pwdata[15:0];
                if (hit(paddr, `P0_OFS_POUT)) pout_r <= pwdata[15:0];
                if (hit(paddr, `P0_OFS_DICFG)) dicfg_r <= pwdata;
                if (hit(paddr, `P0_OFS_DOCFG)) docfg_r <= pwdata;
                if (hit(paddr, `P0_OFS_ROUTE)) route_r <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux and APB answer
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            `P0_OFS_DIR: rd_mux = dir_r;
            `P0_OFS_WAVE: rd_mux = wave_r;
            `P0_OFS_SOUT: rd_mux = sout_r;
            `P0_OFS_SIN: rd_mux = lines_f;
            `P0_OFS_PDIR: rd_mux = {16'h0000, pdir_r};
            `P0_OFS_POUT: rd_mux = {16'h0000, pout_r};
            `P0_OFS_PIN: rd_mux = {16'h0000, pfi_f};
            `P0_OFS_DICFG: rd_mux = dicfg_r;
            `P0_OFS_DOCFG: rd_mux = docfg_r;
            `P0_OFS_STAT: rd_mux = {24'h000000, gen_full, ~fetch_ok & ~pf_v_r, acq_full, acq_empty, 1'b0, err_r};
            `P0_OFS_ROUTE: rd_mux = route_r;
            `P0_OFS_CTRDIR: rd_mux = {30'h0, counter1_direction_input, counter0_direction_input};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    // One wait-free access phase: answer prepared in setup
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~rd_hit;
            if (setup) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic [31:0] p0_out_r, p0_oe_r;
    logic [15:0] pfi_out_r, pfi_oe_r;
    logic c0_r, c1_r;
    wire [3:0] di_pin = route_r[3:0];
    wire [3:0] do_pin = route_r[11:8];
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_pfi
            wire di_here = route_r[`RT_DI_EN_BIT] && di_pin == 4'(gi);
            wire do_here = route_r[`RT_DO_EN_BIT] && do_pin == 4'(gi);
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    pfi_out_r[gi] <= 1'b0;
                    pfi_oe_r[gi] <= 1'b0;
                end else begin
                    // Exported strobes leave inverted
                    pfi_out_r[gi] <= di_here ? ~di_lvl : do_here ? ~do_lvl : pout_r[gi];
                    pfi_oe_r[gi] <= di_here | do_here | pdir_r[gi];
                end
            end
        end
    endgenerate
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            p0_out_r <= '0;
            p0_oe_r <= '0;
            c0_r <= 1'b0;
            c1_r <= 1'b0;
        end else begin
            p0_out_r <= (wave_r & wave_out_r) | (~wave_r & sout_r);
            p0_oe_r <= dir_r;
            c0_r <= lines_f[6];
            c1_r <= lines_f[7];
        end
    end
    assign port0_lines_out = p0_out_r;
    assign port0_lines_oe = p0_oe_r;
    assign programmable_function_pin_out = pfi_out_r;
    assign programmable_function_pin_oe = pfi_oe_r;
    assign counter0_direction_input = c0_r;
    assign counter1_direction_input = c1_r;
    assign acq_dma_valid = acq_v_r;
    assign acq_dma_data = acq_d_r;
    assign gen_dma_ready = gen_rdy_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ovf;
        @(posedge mclk) disable iff (reset) di_edge && acq_full |=> err_r[ERR_OVF] && $stable(aw_ptr_r);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");
    property p_acq;
        @(posedge mclk) disable iff (reset) acq_wr |=> aw_ptr_r == $past(aw_ptr_r) + 1'b1;
    endproperty
    a_acq: assert property (p_acq) else $error("capture not stored");
    property p_unf;
        @(posedge mclk) disable iff (reset) gen_unf |=> err_r[ERR_UNF] && $stable(wave_out_r);
    endproperty
    a_unf: assert property (p_unf) else $error("underflow not flagged");
    property p_ovr;
        @(posedge mclk) disable iff (reset) gen_ovr |=> err_r[ERR_OVR];
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not flagged");
    property p_drive;
        @(posedge mclk) disable iff (reset) take |=> wave_out_r == $past(pf_d_r) ##1 p0_out_r[0] == (!wave_r[0] ?
            sout_r[0] : $past(wave_out_r[0]));
    endproperty
    a_drive: assert property (p_drive) else $error("waveform word not driven");
    property p_rt;
        @(posedge mclk) disable iff (reset) rt_mode && $past(rt_mode) |-> $stable(gr_ptr_r);
    endproperty
    a_rt: assert property (p_rt) else $error("retransmit discarded data");
    property p_dir;
        @(posedge mclk) disable iff (reset) wr_en && hit(paddr, `P0_OFS_DIR) |=> ##1 p0_oe_r == $past(pwdata, 2);
    endproperty
    a_dir: assert property (p_dir) else $error("direction not applied");
    property p_static;
        @(posedge mclk) disable iff (reset) !$stable(sout_r) |-> $past(wr_en) && $past(paddr) == `P0_OFS_SOUT;
    endproperty
    a_static: assert property (p_static) else $error("static output moved without access");
    property p_ctr;
        @(posedge mclk) disable iff (reset) 1'b1 |=> c0_r == $past(lines_f[6]) && c1_r == $past(lines_f[7]);
    endproperty
    a_ctr: assert property (p_ctr) else $error("counter direction mismatch");
    property p_inv;
        @(posedge mclk) disable iff (reset) route_r[`RT_DI_EN_BIT] && $stable(route_r) |=>
            pfi_out_r[$past(di_pin)] == !$past(di_lvl);
    endproperty
    a_inv: assert property (p_inv) else $error("exported strobe not inverted");
endmodule : port0_digital_waveform_io
`default_nettype wire

//--- rtl/port0_defs.svh
// Register offsets, field positions, reset values for the port 0 block
`ifndef PORT0_DEFS_SVH
`define PORT0_DEFS_SVH
`define P0_OFS_DIR 8'h00
`define P0_OFS_WAVE 8'h04
`define P0_OFS_SOUT 8'h08
`define P0_OFS_SIN 8'h0C
`define P0_OFS_PDIR 8'h10
`define P0_OFS_POUT 8'h14
`define P0_OFS_PIN 8'h18
`define P0_OFS_DICFG 8'h1C
`define P0_OFS_DOCFG 8'h20
`define P0_OFS_STAT 8'h24
`define P0_OFS_ROUTE 8'h28
`define P0_OFS_CTRDIR 8'h2C
`define CFG_SRC_LSB 0
`define CFG_SRC_MSB 5
`define CFG_POL_BIT 8
`define CFG_EN_BIT 9
`define CFG_RT_BIT 10
`define ST_OVF_BIT 0
`define ST_UNF_BIT 1
`define ST_OVR_BIT 2
`define RT_DI_EN_BIT 4
`define RT_DO_EN_BIT 12
`define P0_RST_ZERO 32'h0000_0000
`define SRC_COUNT 33
`endif

//--- rtl/port0_pkg.sv
// Types shared by the port 0 block
package port0_pkg;
    typedef logic [31:0] word_t;
    typedef logic [5:0] src_sel_t;
    typedef enum logic [1:0] {
        ERR_OVF = 2'h0,
        ERR_UNF = 2'h1,
        ERR_OVR = 2'h2
    } err_idx_t;
endpackage : port0_pkg

//--- verification/host_dma_model.sv
// Host memory model standing behind both DMA streams
`timescale 1ns/1ps
`default_nettype none
module host_dma_model
    import port0_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic stall,
    input wire logic acq_dma_valid,
    input wire word_t acq_dma_data,
    output logic acq_dma_ready,
    output logic gen_dma_valid,
    output word_t gen_dma_data,
    input wire logic gen_dma_ready
);
    word_t acq_mem [0:127];
    word_t gen_mem [0:15];
    int acq_cnt;
    int gen_idx;
    int gen_len = 0;
    word_t last_r;
    // Stall holds the sink off so the acquisition side backs up
    assign acq_dma_ready = !stall;
    assign gen_dma_valid = gen_idx < gen_len;
    // Idle bus shows the inverse of the last word, never a stale copy
    assign gen_dma_data = gen_dma_valid ? gen_mem[gen_idx] : ~last_r;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            acq_cnt <= 0;
            gen_idx <= 0;
            last_r <= 32'h0000_0000;
        end else begin
            if (acq_dma_valid && acq_dma_ready) begin
                acq_mem[acq_cnt[6:0]] <= acq_dma_data;
                acq_cnt <= acq_cnt + 1;
            end
            if (gen_dma_valid && gen_dma_ready) begin
                last_r <= gen_dma_data;
                gen_idx <= gen_idx + 1;
            end
        end
    end
endmodule : host_dma_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the port 0 digital waveform block
`timescale 1ns/1ps
`default_nettype none
module tb
    import port0_pkg::*;
;
    logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    word_t pwdata = 32'h0000_0000, ext = 32'h0000_0000, rd;
    logic [32:0] src_v = 33'h0_0000_0000;
    word_t prdata, lines_in, lines_out, lines_oe, acq_data, gen_data;
    logic pready, pslverr, acq_valid, acq_ready, gen_valid, gen_ready, ctr0_dir, ctr1_dir;
    logic [15:0] pin_in, pin_out, pin_oe;
    int n_fail = 0, total_checks = 0;
    word_t w [0:2];
    always #2.5 mclk = ~mclk;
    // Pin levels resolved from the DUT's output enables, external drive where they are off
    assign lines_in = (lines_out & lines_oe) | (ext & ~lines_oe);
    assign pin_in = (pin_out & pin_oe) | (src_v[22:7] & ~pin_oe);
    port0_digital_waveform_io u_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port0_lines_in(lines_in), .port0_lines_out(lines_out), .port0_lines_oe(lines_oe),
        .programmable_function_pin_in(pin_in), .programmable_function_pin_out(pin_out),
        .programmable_function_pin_oe(pin_oe), .trigger_bus_line_in(src_v[30:23]), .pxi_star_in(src_v[31]),
        .analog_in_sample_strobe(src_v[0]), .analog_in_convert_strobe(src_v[1]),
        .analog_out_sample_strobe(src_v[2]), .counter0_internal_output(src_v[3]),
        .counter1_internal_output(src_v[4]), .frequency_output(src_v[5]), .change_detection_output(src_v[6]),
        .analog_comparison_event(src_v[32]), .counter0_direction_input(ctr0_dir),
        .counter1_direction_input(ctr1_dir), .acq_dma_valid(acq_valid), .acq_dma_data(acq_data),
        .acq_dma_ready(acq_ready), .gen_dma_valid(gen_valid), .gen_dma_data(gen_data), .gen_dma_ready(gen_ready));
    host_dma_model u_host (.mclk(mclk), .reset(reset), .stall(stall), .acq_dma_valid(acq_valid),
        .acq_dma_data(acq_data), .acq_dma_ready(acq_ready), .gen_dma_valid(gen_valid),
        .gen_dma_data(gen_data), .gen_dma_ready(gen_ready));
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input word_t got, input word_t exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic apb(input logic wr, input logic [7:0] a, input word_t d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input word_t exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk
    task automatic push(input word_t d);
        @(posedge mclk);
        u_host.gen_mem[u_host.gen_len] <= d;
        u_host.gen_len <= u_host.gen_len + 1;
    endtask : push
    // Holds each strobe six cycles and keeps active edges sixteen cycles apart, well above the minimum
    task automatic pulse(input int k);
        cyc(4);
        src_v[k] <= 1'b1;
        cyc(6);
        src_v[k] <= 1'b0;
        cyc(6);
    endtask : pulse
    task automatic wait_acq(input int n);
        for (int i = 0; i < 80 && u_host.acq_cnt != n; i++) begin
            @(posedge mclk);
        end
        chk(32'(u_host.acq_cnt), 32'(n));
        if (u_host.acq_cnt != n) end_sim();
    endtask : wait_acq
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        w[0] = 32'h1357_9BDF;
        w[1] = 32'hF00D_0FF0;
        w[2] = 32'h8001_7FFE;
        cyc(2);
        reset <= 1'b0;
        rchk(8'h00, 32'h0000_0000);
        rchk(8'h24, 32'h0000_0050);
        chk(lines_oe, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk({rd[31:1], err}, 32'h0000_0001);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rchk(8'h0C, 32'h0000_0000);
        ext <= 32'h5A00_00C0;
        src_v <= {10'h000, 16'hAB00, 7'h00};
        apb(1'b1, 8'h00, 32'h0000_FF00);
        apb(1'b1, 8'h08, 32'hA5A5_3C3C);
        apb(1'b1, 8'h10, 32'h0000_00FF);
        apb(1'b1, 8'h14, 32'h0000_1234);
        cyc(6);
        chk(lines_oe, 32'h0000_FF00);
        chk(lines_out & 32'h0000_FF00, 32'h0000_3C00);
        rchk(8'h0C, 32'h5A00_3CC0);
        rchk(8'h18, 32'h0000_AB34);
        chk({pin_oe, pin_out & 16'h00FF}, 32'h00FF_0034);
        chk({ctr1_dir, ctr0_dir}, 32'h0000_0003);
        rchk(8'h2C, 32'h0000_0003);
        apb(1'b1, 8'h00, 32'h0000_0000);
        apb(1'b1, 8'h10, 32'h0000_0000);
        src_v <= 33'h0_0000_0000;
        // Every strobe source, internal and external, in turn
        for (int k = 0; k < 33; k++) begin
            ext <= 32'hC0DE_0000 + 32'(k);
            apb(1'b1, 8'h1C, 32'h0000_0200 + 32'(k));
            cyc(8);
            chk(32'(u_host.acq_cnt), 32'(k));
            pulse(k);
            wait_acq(k + 1);
            chk(u_host.acq_mem[k], 32'hC0DE_0000 + 32'(k));
        end
        src_v[0] <= 1'b1;
        apb(1'b1, 8'h1C, 32'h0000_0300);
        cyc(6);
        src_v[0] <= 1'b0;
        wait_acq(34);
        src_v[0] <= 1'b1;
        cyc(8);
        chk(32'(u_host.acq_cnt), 32'h0000_0022);
        src_v[0] <= 1'b0;
        apb(1'b1, 8'h1C, 32'h0000_0200);
        stall <= 1'b1;
        repeat (24) pulse(0);
        rchk(8'h24, 32'h0000_0061);
        stall <= 1'b0;
        cyc(40);
        apb(1'b1, 8'h24, 32'h0000_0001);
        rchk(8'h24, 32'h0000_0050);
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        apb(1'b1, 8'h04, 32'hFFFF_FFFF);
        apb(1'b1, 8'h20, 32'h0000_0202);
        push(w[0]);
        push(w[1]);
        cyc(6);
        pulse(2);
        chk(lines_out, w[0]);
        pulse(2);
        chk(lines_out, w[1]);
        pulse(2);
        rchk(8'h24, 32'h0000_0052);
        apb(1'b1, 8'h28, 32'h0000_1513);
        cyc(4);
        chk({pin_oe[5], pin_oe[3], pin_out[5], pin_out[3]}, 32'h0000_000F);
        src_v <= 33'h0_0000_0005;
        cyc(6);
        chk({pin_oe[5], pin_oe[3], pin_out[5], pin_out[3]}, 32'h0000_000C);
        src_v <= 33'h0_0000_0000;
        cyc(6);
        apb(1'b1, 8'h24, 32'h0000_0007);
        apb(1'b1, 8'h20, 32'h0000_0602);
        push(w[0]);
        push(w[1]);
        push(w[2]);
        cyc(6);
        for (int i = 0; i < 7; i++) begin
            pulse(2);
            chk(lines_out, w[i % 3]);
        end
        end_sim();
    end
endmodule : tb
`default_nettype wire
